// *** pitc_cfg.svh ***
// Constants for the interval timer counter channel
`ifndef PITC_CFG_SVH
`define PITC_CFG_SVH
`define PITC_CNT_W 16
`define PITC_DIGITS 4
`define PITC_RST_COUNT 16'h0000
`define PITC_ONE 16'h0001
`define PITC_BIN_MAX 16'hFFFF
`define PITC_BCD_MAX 16'h9999
`define PITC_DIG_ZERO 4'h0
`define PITC_DIG_ONE 4'h1
`define PITC_BIN_DIG_MAX 4'hF
`define PITC_BCD_DIG_MAX 4'h9
`endif

// *** pitc_pkg.sv ***
// Types shared by the counter channel files
`default_nettype none
package pitc_pkg;
    // Counting modes as programmed by the control word
    typedef enum logic [2:0]
    {
        PITC_MODE0 = 3'h0,
        PITC_MODE1 = 3'h1,
        PITC_MODE2 = 3'h2,
        PITC_MODE3 = 3'h3,
        PITC_MODE4 = 3'h4,
        PITC_MODE5 = 3'h5
    } pitc_mode_t;
endpackage
`default_nettype wire

// *** pitc_dec.sv ***
// Binary or packed BCD decrement by one of the count value
`include "pitc_cfg.svh"
`default_nettype none
module pitc_dec
    import pitc_pkg::*;
#(
    parameter int DIGITS = `PITC_DIGITS
)
(
    input wire logic [4*DIGITS-1:0] value_i, // Present count
    input wire logic bcd_i, // High for decimal counting
    output logic [4*DIGITS-1:0] dec_o // Count minus one
);
    // Borrow chain between nibbles, first nibble always borrows
    wire logic [DIGITS:0] borrow;
    assign borrow[0] = 1'b1;

    genvar g;
    generate
        for (g = 0; g < DIGITS; g++)
        begin : g_dig
            // Nibble under work
            wire logic [3:0] dig = value_i[4*g+3:4*g];
            wire logic dig_zero = (dig == `PITC_DIG_ZERO);
            // wrap to top value
            // Wrap value of a nibble, 9 in BCD keeps digits in range
            wire logic [3:0] dig_max = bcd_i ? `PITC_BCD_DIG_MAX : `PITC_BIN_DIG_MAX;
            assign dec_o[4*g+3:4*g] = !borrow[g] ? dig :
                                      (dig_zero ? dig_max : dig - `PITC_DIG_ONE);
            assign borrow[g+1] = borrow[g] & dig_zero;
        end
    endgenerate
endmodule
`default_nettype wire

// *** pitc_core.sv ***
// Counter channel core: programming, gate sampling, load and count
`include "pitc_cfg.svh"
`default_nettype none
module pitc_core
    import pitc_pkg::*;
#(
    parameter int CNT_W = `PITC_CNT_W
)
(
    input wire logic clk_i, // System clock, 100 MHz
    input wire logic resetn_i, // Synchronous reset, active low
    input wire logic ctrl_wr_i, // Control word write pulse
    input wire logic [2:0] ctrl_mode_i, // Mode field of control word
    input wire logic ctrl_bcd_i, // Decimal counting select
    input wire logic count_wr_i, // Initial count write pulse
    input wire logic [CNT_W-1:0] count_i, // Initial count value
    input wire logic cnt_clk_i, // Counter clock pin level
    input wire logic gate_i, // Gate pin level
    output logic out_o, // Counter output pin
    output logic [CNT_W-1:0] count_o, // Counting element value
    output logic running_o // Counting element holds a count
);
    // Programmed mode and number base
    pitc_mode_t mode;
    logic bcd;
    // Initial count register and its valid flag
    logic [CNT_W-1:0] init;
    logic have_init;
    // Count written, waiting for the next clock to load
    logic load_pend;
    // Previous pin levels for edge detection
    logic cnt_clk_q;
    logic gate_q;
    // Gate level taken at counter clock rise
    logic gate_lvl;
    // Edge capture flip-flop and its sampled copy
    logic trig_ff;
    logic trig_smp;

    // Counter clock edges seen on the system clock
    wire logic clk_rise = cnt_clk_i & ~cnt_clk_q;
    wire logic clk_fall = ~cnt_clk_i & cnt_clk_q;
    // Rising edge of the gate pin
    wire logic gate_edge = gate_i & ~gate_q;

    // Mode classes
    // periodic modes use both
    wire logic lvl_mode = (mode == PITC_MODE0) || (mode == PITC_MODE2) ||
                          (mode == PITC_MODE3) || (mode == PITC_MODE4);
    wire logic edge_mode = (mode == PITC_MODE1) || (mode == PITC_MODE2) ||
                           (mode == PITC_MODE3) || (mode == PITC_MODE5);
    wire logic per_mode = (mode == PITC_MODE2) || (mode == PITC_MODE3);
    // Modes that load on a count write; modes 2 and 3 also load on a trigger
    wire logic soft_mode = lvl_mode;
    // Level enable; edge-only modes are always enabled
    // gate level enable
    wire logic enable = ~lvl_mode | gate_lvl;

    // Decrement unit output
    logic [CNT_W-1:0] dec_val;
    // Load from initial count on this fall
    wire logic do_load = clk_fall & have_init & (load_pend | (trig_smp & edge_mode));
    // Periodic expiry, count one reached in modes 2 and 3
    // periodic reload point
    wire logic expire = per_mode & (count_o == `PITC_ONE);
    // Decrement on this fall
    wire logic do_count = clk_fall & running_o & enable & ~do_load;
    // Next count value
    wire logic [CNT_W-1:0] next_count = (do_load | expire) ? init : dec_val;
    // Reaching zero in mode 0 raises the output
    wire logic reach_zero = do_count & ~expire & (count_o == `PITC_ONE);
    // Output level forced by a control word
    wire logic init_level = (pitc_mode_t'(ctrl_mode_i) != PITC_MODE0);
    // New count write arms a load in modes 0, 2, 3 and 4 unless a periodic sequence is running
    wire logic next_load_pend = soft_mode & ~(per_mode & running_o);

    // Decrement unit, binary or BCD
    pitc_dec #(
        .DIGITS(CNT_W / 4)
    ) u_dec (
        .value_i(count_o),
        .bcd_i(bcd),
        .dec_o(dec_val)
    );

    // Pin history for edge detection
    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            cnt_clk_q <= 1'b0;
            gate_q <= 1'b0;
        end
        else
        begin
            cnt_clk_q <= cnt_clk_i;
            gate_q <= gate_i;
        end
    end

    // Mode, base and initial count registers
    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            mode <= PITC_MODE0;
            bcd <= 1'b0;
            init <= `PITC_RST_COUNT;
            have_init <= 1'b0;
        end
        else if (ctrl_wr_i)
        begin
            mode <= pitc_mode_t'(ctrl_mode_i);
            bcd <= ctrl_bcd_i;
            have_init <= 1'b0;
        end
        else if (count_wr_i)
        begin
            // Zero is kept as is and counts as the largest value
            // zero is largest
            init <= count_i;
            have_init <= 1'b1;
        end
    end

    // gate level only at clock rise
    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
            gate_lvl <= 1'b0;
        else if (clk_rise)
            gate_lvl <= gate_i;
    end

    // Edge capture flip-flop; a new edge wins over the clear at counter clock rise
    always_ff @(posedge clk_i)
    begin
        if (!resetn_i || ctrl_wr_i)
        begin
            trig_ff <= 1'b0;
            trig_smp <= 1'b0;
        end
        else
        begin
            if (gate_edge & edge_mode)
                trig_ff <= 1'b1;
            else if (clk_rise)
                trig_ff <= 1'b0;
            if (clk_rise)
                trig_smp <= trig_ff;
            else if (do_load)
                trig_smp <= 1'b0;
        end
    end

    // Load request after a count write
    always_ff @(posedge clk_i)
    begin
        if (!resetn_i || ctrl_wr_i)
            load_pend <= 1'b0;
        else if (count_wr_i)
            load_pend <= next_load_pend;
        else if (do_load)
            load_pend <= 1'b0;
    end

    // Counting element, changes only on counter clock fall
    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            count_o <= `PITC_RST_COUNT;
            running_o <= 1'b0;
        end
        else if (ctrl_wr_i)
            running_o <= 1'b0;
        else if (do_load | do_count)
        begin
            count_o <= next_count;
            running_o <= 1'b1;
        end
    end

    // Output pin level
    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
            out_o <= 1'b0;
        else if (ctrl_wr_i)
            out_o <= init_level;
        else if (mode == PITC_MODE0 && do_load)
            out_o <= 1'b0;
        else if (mode == PITC_MODE0 && reach_zero)
            out_o <= 1'b1;
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);

    // Steps of a load after a count write
    sequence s_armed;
        load_pend && clk_fall && have_init && !ctrl_wr_i && !count_wr_i;
    endsequence
    sequence s_loaded;
        running_o && count_o == $past(init) && !load_pend;
    endsequence

    ctrl_out_init_a: assert property (ctrl_wr_i |=>
        out_o == ($past(ctrl_mode_i) != 3'h0) && !running_o && !trig_ff && !load_pend)
        else $error("control word did not reset the channel");
    gate_sample_a: assert property (!clk_rise |=> $stable(gate_lvl))
        else $error("gate level changed away from clock rise");
    gate_level_a: assert property (running_o && lvl_mode && !gate_lvl &&
        clk_fall && !do_load && !ctrl_wr_i |=> $stable(count_o))
        else $error("counting with gate low in a level mode");
    trig_set_a: assert property (gate_edge && edge_mode && !ctrl_wr_i |=> trig_ff)
        else $error("gate rise did not set the trigger");
    trig_clear_a: assert property (clk_rise && !gate_edge && !ctrl_wr_i |=>
        !trig_ff && trig_smp == $past(trig_ff))
        else $error("trigger not sampled and cleared");
    both_sense_a: assert property (per_mode && trig_smp && clk_fall &&
        have_init && !ctrl_wr_i |=> count_o == $past(init))
        else $error("trigger ignored in a periodic mode");
    fall_only_a: assert property (!clk_fall && !ctrl_wr_i |=> $stable(count_o))
        else $error("count moved away from clock fall");
    zero_wrap_a: assert property (do_count && !per_mode && count_o == 16'h0000 |=>
        count_o == ($past(bcd) ? `PITC_BCD_MAX : `PITC_BIN_MAX))
        else $error("count did not wrap from zero");
    period_reload_a: assert property (do_count && expire |=> count_o == $past(init))
        else $error("periodic mode did not reload");
    next_load_a: assert property (s_armed |=> s_loaded)
        else $error("written count not loaded on clock fall");
    bcd_digit_a: assert property (do_count && bcd && !expire &&
        count_o[3:0] == 4'h0 |=> count_o[3:0] == 4'h9)
        else $error("decimal digit left range on borrow");
endmodule
`default_nettype wire

// *** pitc_clk_src.sv ***
// Counter clock source standing in for the system side
`default_nettype none
module pitc_clk_src
(
    input wire logic clk_i, // System clock
    input wire logic resetn_i, // Synchronous reset, active low
    output logic cnt_clk_o // Counter clock, four system cycles a period
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] phase = 2'h0; // Divider phase
    // Divider steps on the rising edge so the bench never races it
    always @(posedge clk_i)
    begin
        phase <= resetn_i ? phase + 2'h1 : 2'h0;
    end
    // Two system cycles high, two low
    assign cnt_clk_o = phase[1];
endmodule
`default_nettype wire

// *** tb.sv ***
// Self-checking bench for the counter channel core
`default_nettype none
module tb
    import pitc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0; // System clock
    logic resetn_i = 1'b0; // Reset, active low
    logic ctrl_wr = 1'b0; // Control write strobe
    logic [2:0] ctrl_mode = 3'h0; // Mode field
    logic ctrl_bcd = 1'b0; // Decimal select
    logic count_wr = 1'b0; // Count write strobe
    logic [15:0] count = 16'h0000; // Initial count
    logic gate = 1'b1; // Gate pin
    logic cnt_clk; // Counter clock from the source model
    logic out; // Output pin
    logic [15:0] cnt_val; // Counting element
    logic running; // Element loaded
    int miscompares = 0; // Mismatch count
    int n_tests = 0; // Comparison count
    pitc_clk_src pitc_clk_src_inst (.clk_i(clk_i), .resetn_i(resetn_i), .cnt_clk_o(cnt_clk));
    pitc_core pitc_core_inst (.clk_i(clk_i), .resetn_i(resetn_i), .ctrl_wr_i(ctrl_wr),
        .ctrl_mode_i(ctrl_mode), .ctrl_bcd_i(ctrl_bcd), .count_wr_i(count_wr),
        .count_i(count), .cnt_clk_i(cnt_clk), .gate_i(gate), .out_o(out),
        .count_o(cnt_val), .running_o(running));
    // Clock, 10 ns period
    initial
    begin
        forever #5 clk_i = ~clk_i;
    end
    // Prints the counts and the verdict, then stops
    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Compares one value against its expectation
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    // Control word write, then one settling cycle
    task automatic wr_ctrl(input logic [2:0] m, input logic b);
        ctrl_mode = m;
        ctrl_bcd = b;
        ctrl_wr = 1'b1;
        @(negedge clk_i);
        ctrl_wr = 1'b0;
        @(negedge clk_i);
    endtask
    // Initial count write, placed just after a counter clock fall so that
    // the load lands on the fall that the next fall() call waits for
    task automatic wr_count(input logic [15:0] v);
        @(negedge cnt_clk);
        @(negedge clk_i);
        count = v;
        count_wr = 1'b1;
        @(negedge clk_i);
        count_wr = 1'b0;
    endtask
    // Waits for a counter clock fall and for the core to act on it
    task automatic fall();
        @(negedge cnt_clk);
        repeat (2) @(negedge clk_i);
    endtask
    task automatic t_mode2();
        wr_ctrl(PITC_MODE2, 1'b0);
        check({15'h0000, out}, 16'h0001);
        gate = 1'b0;
        wr_count(16'h0002);
        gate = 1'b1;
        fall();
        check(cnt_val, 16'h0002);
        fall();
        check(cnt_val, 16'h0001);
        fall();
        check(cnt_val, 16'h0002);
    endtask
    // load on fall, count down and wrap
    task automatic t_mode0();
        wr_ctrl(PITC_MODE0, 1'b0);
        check({14'h0000, running, out}, 16'h0000);
        wr_count(16'h0003);
        fall();
        check({15'h0000, running}, 16'h0001);
        check(cnt_val, 16'h0003);
        fall();
        check(cnt_val, 16'h0002);
        fall();
        fall();
        check({15'h0000, out}, 16'h0001);
        fall();
        check(cnt_val, 16'hFFFF);
    endtask
    // decimal borrow, zero as largest count
    task automatic t_bcd();
        wr_ctrl(PITC_MODE0, 1'b1);
        wr_count(16'h0010);
        fall();
        fall();
        check(cnt_val, 16'h0009);
        wr_count(16'h0000);
        fall();
        fall();
        check(cnt_val, 16'h9999);
    endtask
    // gate level taken at the counter clock rise
    task automatic t_mode4();
        gate = 1'b0;
        wr_ctrl(PITC_MODE4, 1'b0);
        wr_count(16'h0005);
        fall();
        fall();
        check(cnt_val, 16'h0005);
        gate = 1'b1;
        fall();
        check(cnt_val, 16'h0004);
    endtask
    // short gate pulse caught and used as trigger
    task automatic t_mode1();
        gate = 1'b0;
        wr_ctrl(PITC_MODE1, 1'b0);
        wr_count(16'h0004);
        fall();
        check({15'h0000, running}, 16'h0000);
        gate = 1'b1;
        @(negedge clk_i);
        gate = 1'b0;
        fall();
        check({15'h0000, running}, 16'h0001);
        check(cnt_val, 16'h0004);
        fall();
        check(cnt_val, 16'h0003);
    endtask
    // Watchdog against a hang
    initial
    begin
        repeat (4000) @(posedge clk_i);
        miscompares++;
        test_done();
    end
    // Main sequence
    initial
    begin
        repeat (3) @(negedge clk_i);
        resetn_i = 1'b1;
        @(negedge clk_i);
        t_mode2();
        t_mode0();
        t_bcd();
        t_mode4();
        t_mode1();
        test_done();
    end
endmodule
`default_nettype wire
